// File: core/bslc_pkg.sv
// Constants and types shared by the bridge state and loop control logic.
// Assumes a single 50 MHz clock; hello, base tick and retry times are turned into cycle counts here.
`default_nettype none

package bslc_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ        = 50_000_000;

  // Topology control message interval
  localparam int unsigned HELLO_TIME_S  = 1;
  localparam int unsigned HELLO_CYCLES  = HELLO_TIME_S * CLK_HZ;

  // One-second base tick for aging and hold timing
  localparam int unsigned SEC_TIME_S    = 1;
  localparam int unsigned SEC_CYCLES    = SEC_TIME_S * CLK_HZ;

  // Wait before retrying a failed, non-fatal initialization
  localparam int unsigned RETRY_TIME_S  = 5;
  localparam int unsigned RETRY_CYCLES  = RETRY_TIME_S * CLK_HZ;

  // Address aging intervals, in seconds
  localparam int unsigned AGE_W         = 8;
  localparam int unsigned AGE_NORMAL_MIN = 2;
  localparam logic [AGE_W-1:0] AGE_NORMAL_S = AGE_W'(AGE_NORMAL_MIN * 60);
  localparam logic [AGE_W-1:0] AGE_FAST_S   = 8'h1E;
  localparam logic [AGE_W-1:0] FAST_HOLD_S  = 8'h1E;
  localparam logic [AGE_W-1:0] AGE_ZERO     = 8'h00;
  localparam logic [AGE_W-1:0] AGE_ONE      = 8'h01;

  // Root priority
  localparam int unsigned PRIO_W       = 16;
  localparam logic [PRIO_W-1:0] PRIO_DEFAULT = 16'h8000;

  // Protocol variant: 1 = standard, 0 = legacy
  localparam logic VARIANT_DEFAULT = 1'b1;

  // Overall bridge state, readable by management as a 2-bit code
  typedef enum logic [1:0] {
    BST_OFF,
    BST_INIT,
    BST_OPERATE,
    BST_BROKEN
  } bslc_state_t;

  // Per-port state driven toward the ports
  typedef enum logic [1:0] {
    PS_DISABLED,
    PS_BLOCKING,
    PS_FORWARDING
  } bslc_port_t;

endpackage

`default_nettype wire

// File: core/bslc_tick.sv
// Periodic one-cycle tick generator.
// Assumes run_i comes from logic on mclk_i; counting restarts whenever run_i drops.
`default_nettype none

module bslc_tick #(
  parameter int unsigned PERIOD = 4
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic run_i,
  output logic      tick_o
);
  import bslc_pkg::*;

  localparam int unsigned CW = (PERIOD > 2) ? $clog2(PERIOD) : 1;
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } bslc_tick_st_t;

  localparam bslc_tick_st_t RST_ST = '{cnt: '0, tick: 1'b0};

  bslc_tick_st_t q;
  bslc_tick_st_t next_q;

  always_comb begin
    next_q      = q;
    next_q.tick = 1'b0;
    if (!run_i) begin
      next_q.cnt = '0;
    end else if (q.cnt == LAST) begin
      next_q.cnt  = '0;
      next_q.tick = 1'b1;
    end else begin
      next_q.cnt = q.cnt + CW'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q <= RST_ST;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign tick_o = q.tick;

  tick_run_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tick_o |-> $past(run_i))
    else $error("tick raised while not running");

endmodule

`default_nettype wire

// File: core/bslc_ctrl.sv
// Overall bridge state machine and loop control supervision.
// Assumes port faults arrive asynchronously from pins; all other inputs come from
// logic on mclk_i, and event inputs are one-cycle pulses taken while ce_i is high.
//
// What this block does
// - Block forwarding on ports closing a loop.
// - Drive each port's operating state directly.
// - Aging 2 minutes, 30 seconds after reconfiguration.
// - Management reads status and sets priority.
// - Exactly one of four overall bridge states.
// - Power-up enters initializing; off only unpowered.
// - Successful initialization leads to operating.
// - Failed initialization retries or goes fatal.
// - Fatal state only for fatal errors.
// - Operating returns to initializing on failure.
// - All ports faulted forces fatal state.
// - One healthy port allows operating state.
// - Accept reset command; not all states reachable.
// - Backup bridge forwards no frames at all.
// - Send topology messages every second.
// - Topology has single paths, all LANs connected.
// - Two protocol variants, selected automatically.
// - Learned entries age out; managed ones never.
`default_nettype none

module bslc_ctrl #(
  parameter int unsigned NP        = 2,
  parameter int unsigned HELLO_CYC = bslc_pkg::HELLO_CYCLES,
  parameter int unsigned SEC_CYC   = bslc_pkg::SEC_CYCLES,
  parameter int unsigned RETRY_CYC = bslc_pkg::RETRY_CYCLES
) (
  input  wire logic                          mclk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          ce_i,
  // Port health and tree computation results
  input  wire logic [NP-1:0]                 port_fault_i,
  input  wire logic [NP-1:0]                 loop_block_i,
  input  wire logic                          backup_i,
  input  wire logic                          topo_change_i,
  // Peer message kind heard on any port
  input  wire logic                          peer_kind_vld_i,
  input  wire logic                          peer_kind_i,
  // Self-test handshake
  input  wire logic                          init_done_i,
  input  wire logic                          init_pass_i,
  input  wire logic                          init_fatal_i,
  input  wire logic                          op_fail_i,
  // Management
  input  wire logic                          mgmt_reset_i,
  input  wire logic                          prio_wr_i,
  input  wire logic [bslc_pkg::PRIO_W-1:0]   prio_i,
  output bslc_pkg::bslc_state_t              bridge_state_o,
  output logic [bslc_pkg::PRIO_W-1:0]        root_prio_o,
  output logic                               variant_o,
  // Toward ports, address store and test logic
  output bslc_pkg::bslc_port_t [NP-1:0]      port_state_o,
  output logic [NP-1:0]                      forward_en_o,
  output logic [bslc_pkg::AGE_W-1:0]         age_sec_o,
  output logic                               age_tick_o,
  output logic                               hello_send_o,
  output logic                               init_start_o
);
  import bslc_pkg::*;

  typedef struct packed {
    bslc_state_t             bst;
    logic [NP-1:0]           sync1;
    logic [NP-1:0]           sync2;
    logic                    testing;
    logic                    retry_wait;
    logic                    init_start;
    bslc_port_t [NP-1:0]     pstate;
    logic [NP-1:0]           fwd;
    logic [AGE_W-1:0]        fast_left;
    logic [AGE_W-1:0]        age_sec;
    logic                    age_tick;
    logic                    hello;
    logic                    variant;
    logic [PRIO_W-1:0]       prio;
  } bslc_ctrl_st_t;

  localparam bslc_ctrl_st_t RST_ST = '{
    bst:        BST_OFF,
    sync1:      '0,
    sync2:      '0,
    testing:    1'b0,
    retry_wait: 1'b0,
    init_start: 1'b0,
    pstate:     '{default: PS_DISABLED},
    fwd:        '0,
    fast_left:  AGE_ZERO,
    age_sec:    AGE_NORMAL_S,
    age_tick:   1'b0,
    hello:      1'b0,
    variant:    VARIANT_DEFAULT,
    prio:       PRIO_DEFAULT
  };

  bslc_ctrl_st_t q;
  bslc_ctrl_st_t next_q;

  logic hello_tick;
  logic sec_tick;
  logic retry_tick;
  logic all_fault;

  assign all_fault = &q.sync2;

  bslc_tick #(.PERIOD(HELLO_CYC)) u_hello_tick (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .run_i   (q.bst == BST_OPERATE),
    .tick_o  (hello_tick)
  );

  bslc_tick #(.PERIOD(SEC_CYC)) u_sec_tick (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .run_i   (q.bst != BST_OFF),
    .tick_o  (sec_tick)
  );

  bslc_tick #(.PERIOD(RETRY_CYC)) u_retry_tick (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .run_i   ((q.bst == BST_INIT) && q.retry_wait),
    .tick_o  (retry_tick)
  );

  always_comb begin
    next_q            = q;
    next_q.sync1      = port_fault_i;
    next_q.sync2      = q.sync1;
    next_q.init_start = 1'b0;

    unique case (q.bst)
      BST_OFF: begin
        next_q.bst        = BST_INIT;
        next_q.testing    = 1'b0;
        next_q.retry_wait = 1'b0;
      end
      BST_INIT: begin
        if (!q.testing && !q.retry_wait) begin
          next_q.init_start = 1'b1;
          next_q.testing    = 1'b1;
        end else if (q.retry_wait && retry_tick) begin
          next_q.retry_wait = 1'b0;
        end else if (q.testing && init_done_i) begin
          next_q.testing = 1'b0;
          // fatal or retry by failure kind
          if (init_fatal_i) begin
            next_q.bst = BST_BROKEN;
          end else if (init_pass_i) begin
            next_q.bst = BST_OPERATE;
          end else begin
            next_q.retry_wait = 1'b1;
          end
        end
      end
      BST_OPERATE: begin
        if (op_fail_i) begin
          next_q.bst        = BST_INIT;
          next_q.testing    = 1'b0;
          next_q.retry_wait = 1'b0;
        end
      end
      BST_BROKEN: begin
        next_q.bst = BST_BROKEN;
      end
    endcase

    if (mgmt_reset_i && (q.bst != BST_OFF)) begin
      next_q.bst        = BST_INIT;
      next_q.testing    = 1'b0;
      next_q.retry_wait = 1'b0;
    end

    if (all_fault && (q.bst != BST_OFF)) begin
      next_q.bst = BST_BROKEN;
    end

    for (int p = 0; p < NP; p++) begin
      if ((next_q.bst != BST_OPERATE) || q.sync2[p]) begin
        next_q.pstate[p] = PS_DISABLED;
      end else if (loop_block_i[p] || backup_i) begin
        next_q.pstate[p] = PS_BLOCKING;
      end else begin
        next_q.pstate[p] = PS_FORWARDING;
      end
      next_q.fwd[p] = (next_q.pstate[p] == PS_FORWARDING);
    end

    if (topo_change_i) begin
      next_q.fast_left = FAST_HOLD_S;
    end else if (sec_tick && (q.fast_left != AGE_ZERO)) begin
      next_q.fast_left = q.fast_left - AGE_ONE;
    end
    next_q.age_sec = (next_q.fast_left != AGE_ZERO) ? AGE_FAST_S : AGE_NORMAL_S;

    next_q.age_tick = sec_tick;

    next_q.hello = hello_tick && (q.bst == BST_OPERATE);

    if (peer_kind_vld_i) begin
      next_q.variant = peer_kind_i;
    end

    if (prio_wr_i) begin
      next_q.prio = prio_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q <= RST_ST;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  // state code straight from the register
  assign bridge_state_o = q.bst;
  assign root_prio_o    = q.prio;
  assign variant_o      = q.variant;
  assign port_state_o   = q.pstate;
  assign forward_en_o   = q.fwd;
  assign age_sec_o      = q.age_sec;
  assign age_tick_o     = q.age_tick;
  assign hello_send_o   = q.hello;
  assign init_start_o   = q.init_start;

  // Checks
  logic [NP-1:0] fwd_code;
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      fwd_code[p] = (q.pstate[p] == PS_FORWARDING);
    end
  end

  loop_cut_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_i |=> ((forward_en_o & $past(loop_block_i)) == '0))
    else $error("forwarding on a loop port");

  port_state_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    forward_en_o == fwd_code)
    else $error("forward enable disagrees with port state");

  age_fast_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && topo_change_i) |=> (age_sec_o == AGE_FAST_S))
    else $error("aging not shortened after reconfiguration");

  age_normal_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.fast_left == AGE_ZERO) |-> (age_sec_o == AGE_NORMAL_S))
    else $error("aging not normal outside hold");

  prio_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && prio_wr_i) |=> (root_prio_o == $past(prio_i)))
    else $error("root priority write lost");

  power_up_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && (q.bst == BST_OFF) && !all_fault) |=> (q.bst == BST_INIT))
    else $error("power-up did not enter initializing");

  never_off_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.bst != BST_OFF) |=> (q.bst != BST_OFF))
    else $error("off state entered while powered");

  init_ok_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && (q.bst == BST_INIT) && q.testing && init_done_i && init_pass_i
     && !init_fatal_i && !all_fault && !mgmt_reset_i) |=> (q.bst == BST_OPERATE))
    else $error("passed initialization did not operate");

  init_fatal_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && (q.bst == BST_INIT) && q.testing && init_done_i && init_fatal_i
     && !mgmt_reset_i) |=> (q.bst == BST_BROKEN))
    else $error("fatal failure did not go broken");

  broken_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ((q.bst == BST_BROKEN) && !mgmt_reset_i) |=> (q.bst == BST_BROKEN))
    else $error("left broken state without reset");

  retry_start_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && (q.bst == BST_INIT) && q.retry_wait && retry_tick && !mgmt_reset_i
     && !all_fault) ##1 ce_i |=> init_start_o)
    else $error("retry did not restart initialization");

  op_fail_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && (q.bst == BST_OPERATE) && op_fail_i && !all_fault) |=> (q.bst == BST_INIT))
    else $error("operating failure did not reinitialize");

  all_fault_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && all_fault && (q.bst != BST_OFF)) |=> (q.bst == BST_BROKEN))
    else $error("all ports faulted but not broken");

  mgmt_reset_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && mgmt_reset_i && (q.bst != BST_OFF) && !all_fault) |=> (q.bst == BST_INIT))
    else $error("management reset ignored");

  backup_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && backup_i) |=> (forward_en_o == '0))
    else $error("backup bridge forwarding");

  hello_op_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (hello_send_o && ce_i) |-> ($past(q.bst) == BST_OPERATE) ##1 !hello_send_o)
    else $error("hello outside operating or not a pulse");

  variant_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && peer_kind_vld_i) |=> (variant_o == $past(peer_kind_i)))
    else $error("variant not taken from peer");

  reach_op_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.bst == BST_INIT) ##1 (q.bst == BST_OPERATE));

  reach_broken_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    (q.bst == BST_INIT) ##1 (q.bst == BST_BROKEN));

  retry_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    q.retry_wait ##1 !q.retry_wait ##1 init_start_o);

  topo_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    (age_sec_o == AGE_FAST_S) ##1 (age_sec_o == AGE_NORMAL_S));

endmodule

`default_nettype wire

// File: verification/bslc_test_model.sv
// Self-test partner: answers every start pulse with one done pulse.
// Assumes the bench sets mode_i (0 pass, 1 retryable fail, 2 fatal).
`default_nettype none

module bslc_test_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_i,
  input  wire logic [1:0] mode_i,
  output logic            done_o,
  output logic            pass_o,
  output logic            fatal_o
);
  timeunit 1ns;
  timeprecision 1ns;

  int cnt;

  initial begin
    done_o = 1'b0;
    pass_o = 1'b0;
    fatal_o = 1'b0;
    cnt = 0;
  end

  always @(negedge mclk_i) begin
    if (rst_n_i && cnt == 1) begin
      done_o <= 1'b1;
      pass_o <= (mode_i == 2'h0);
      fatal_o <= (mode_i == 2'h2);
    end else begin
      // Qualifiers wander outside the done cycle
      done_o <= 1'b0;
      pass_o <= ~pass_o;
      fatal_o <= pass_o;
    end
    if (!rst_n_i) begin
      cnt <= 0;
    end else if (start_i === 1'b1) begin
      cnt <= 3;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for bslc_ctrl with shortened timers.
// Assumes bslc_pkg, bslc_ctrl and bslc_test_model are compiled first.
`default_nettype none

module tb_top;
  import bslc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int HC = 8;
  localparam int SC = 8;
  localparam int RC = 16;

  logic                   mclk_i = 1'b0;
  logic                   rst_n_i = 1'b0;
  logic                   ce_i = 1'b1;
  logic [1:0]             fault = 2'h0;
  logic [1:0]             lb = 2'h0;
  logic                   bk = 1'b0;
  logic                   tc = 1'b0;
  logic                   pkv = 1'b0;
  logic                   pk = 1'b0;
  logic                   opf = 1'b0;
  logic                   mrs = 1'b0;
  logic                   pwr = 1'b0;
  logic [15:0]            prio = 16'h0;
  logic [1:0]             mode = 2'h0;
  logic                   idn, ips, ifa;
  bslc_state_t            st;
  logic [15:0]            rprio;
  logic                   var_o;
  bslc_port_t [1:0]       pst;
  logic [1:0]             fwd;
  logic [7:0]             age;
  logic                   atick, hello, istart;
  logic [31:0]            seed = 32'h5776;
  int                     error_cnt = 0;
  int                     n_tests = 0;

  always #10 mclk_i = ~mclk_i;

  bslc_ctrl #(.NP(2), .HELLO_CYC(HC), .SEC_CYC(SC), .RETRY_CYC(RC)) uut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .port_fault_i(fault),
    .loop_block_i(lb), .backup_i(bk), .topo_change_i(tc),
    .peer_kind_vld_i(pkv), .peer_kind_i(pk), .init_done_i(idn),
    .init_pass_i(ips), .init_fatal_i(ifa), .op_fail_i(opf),
    .mgmt_reset_i(mrs), .prio_wr_i(pwr), .prio_i(prio),
    .bridge_state_o(st), .root_prio_o(rprio), .variant_o(var_o),
    .port_state_o(pst), .forward_en_o(fwd), .age_sec_o(age),
    .age_tick_o(atick), .hello_send_o(hello), .init_start_o(istart)
  );

  bslc_test_model selftest (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .start_i(istart), .mode_i(mode),
    .done_o(idn), .pass_o(ips), .fatal_o(ifa)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic exp_fwd(input logic f, input logic l, input logic b);
    return !f && !l && !b;
  endfunction

  function automatic logic sel(input int w);
    return (w == 0) ? hello : ((w == 1) ? atick : istart);
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic wait_st(input bslc_state_t s, input int lim);
    int i;
    i = 0;
    while (st !== s && i < lim) begin
      cyc(1);
      i++;
    end
    chk(st === s, "state not reached");
    if (st !== s) end_of_test();
  endtask

  // Cycles until the selected pulse is next seen
  task automatic gap(input int w, output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (sel(w) !== 1'b1 && n < 400);
    chk(sel(w) === 1'b1, "pulse missing");
    if (n >= 400) end_of_test();
  endtask

  initial begin
    repeat (100000) @(posedge mclk_i);
    error_cnt++;
    $display("[FAIL] %0t run too long", $time);
    end_of_test();
  end

  initial begin
    int  n;
    int  i;
    logic e;
    cyc(15);
    chk(st === BST_OFF && fwd === 2'h0, "reset state");
    chk(pst[0] === PS_DISABLED && pst[1] === PS_DISABLED, "reset ports");
    chk(age === 8'h78 && rprio === 16'h8000 && var_o === 1'b1, "reset values");
    cyc(1);
    rst_n_i = 1'b1;
    cyc(1);
    chk(st === BST_INIT, "power-up init");
    wait_st(BST_OPERATE, 20);
    chk(fwd === 2'h3, "ports forward");
    $display("test startup done");

    for (int k = 0; k < 8; k++) begin
      lb = k[1:0];
      bk = k[2];
      cyc(1);
      for (int p = 0; p < 2; p++) begin
        e = exp_fwd(1'b0, lb[p], bk);
        chk(fwd[p] === e, "forward enable");
        chk(pst[p] === (e ? PS_FORWARDING : PS_BLOCKING), "port state");
      end
    end
    lb = 2'h0;
    bk = 1'b0;
    $display("test gating done");

    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      prio = (k == 0) ? 16'h0000 : ((k == 1) ? 16'hFFFF : seed[15:0]);
      pk = seed[16];
      pwr = 1'b1;
      pkv = 1'b1;
      cyc(1);
      pwr = 1'b0;
      pkv = 1'b0;
      chk(rprio === prio, "root priority");
      chk(var_o === pk, "variant");
    end
    $display("test management done");

    gap(0, n);
    gap(0, n);
    chk(n == HC, "hello spacing");
    // Let the pulse drop first, a frozen pulse would stay high
    cyc(1);
    ce_i = 1'b0;
    e = 1'b0;
    repeat (3 * HC) begin
      cyc(1);
      e = e | (hello === 1'b1);
    end
    ce_i = 1'b1;
    chk(!e && st === BST_OPERATE, "frozen while disabled");
    $display("test hello done");

    tc = 1'b1;
    cyc(1);
    tc = 1'b0;
    chk(age === 8'h1E, "fast aging");
    n = 0;
    i = 0;
    while (age !== 8'h78 && i < 600) begin
      cyc(1);
      i++;
      if (atick === 1'b1) n++;
    end
    chk(age === 8'h78 && n >= 29 && n <= 31, "aging hold");
    gap(1, n);
    gap(1, n);
    chk(n == SC, "age tick spacing");
    $display("test aging done");

    opf = 1'b1;
    cyc(1);
    opf = 1'b0;
    chk(st === BST_INIT, "self-check fail");
    wait_st(BST_OPERATE, 20);
    mode = 2'h1;
    opf = 1'b1;
    cyc(1);
    opf = 1'b0;
    gap(2, n);
    gap(2, n);
    chk(n >= RC && n <= RC + 8 && st === BST_INIT, "retry");
    mode = 2'h2;
    wait_st(BST_BROKEN, RC + 20);
    mode = 2'h0;
    mrs = 1'b1;
    cyc(1);
    mrs = 1'b0;
    chk(st === BST_INIT, "management reset");
    wait_st(BST_OPERATE, 20);
    $display("test init done");

    fault = 2'h3;
    wait_st(BST_BROKEN, 6);
    chk(fwd === 2'h0, "no relay");
    fault = 2'h2;
    cyc(4);
    mrs = 1'b1;
    cyc(1);
    mrs = 1'b0;
    wait_st(BST_OPERATE, 20);
    chk(pst[0] === PS_FORWARDING && pst[1] === PS_DISABLED, "one port");
    $display("test faults done");
    end_of_test();
  end
endmodule

`default_nettype wire
